/* pkg/slfm_pkg.sv */
package slfm_pkg;

    localparam int NCH = 4;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DRV_EN_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;

    // Reset values and register masks
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [7:0] DRV_EN_RESET = 8'h00;
    localparam logic [31:0] CTRL_MASK = 32'h0000_3fff;
    localparam logic [31:0] DRV_EN_MASK = 32'h0000_00ff;

    // Amplitude threshold codes
    localparam logic [1:0] AMP_DISABLED = 2'h0;

    // Timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SETTLE_TIME_NS = 2000000;
    localparam int SETTLE_CYCLES = SETTLE_TIME_NS / CLK_PERIOD_NS;
    localparam int RC_INTERVAL_CHARS = 4096;
    localparam int RC_WINDOW_PPM = 1500;
    localparam int TRANS_MAX_CHARS = 6;
    localparam int REF_TIMEOUT_CYCLES = 64;

    // AHB
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;

    typedef struct packed {
        logic [1:0] amp_threshold;
        logic [NCH-1:0] refclk_mult;
        logic [NCH-1:0] rx_enable;
        logic [NCH-1:0] loopback;
    } slfm_ctrl_type;

    typedef struct packed {
        logic [NCH-1:0] settling;
        logic [NCH-1:0] trans_ok;
        logic [NCH-1:0] ref_present;
        logic [NCH-1:0] vco_forced;
        logic [NCH-1:0] link_ok;
    } slfm_status_type;

    typedef struct packed {
        logic [2*NCH-1:0] secondary_amp;
        logic [2*NCH-1:0] primary_amp;
        logic [NCH-1:0] lockout;
        logic [NCH-1:0] line_sel;
        logic [NCH-1:0] tx_bit;
        logic [NCH-1:0] secondary_bit;
        logic [NCH-1:0] primary_bit;
        logic [NCH-1:0] ref_clk;
        logic [NCH-1:0] rx_clk;
    } slfm_pin_type;

endpackage

/* hw/slfm_top.sv */
`timescale 1ns/1ps
// Functional notes
// - Loopback forces every enabled driver of the channel to static one.
// - Each driver has its own enable; a cleared enable powers it down.
// - Both drivers disabled powers down the channel transmit logic.
// - Reset clears all driver enables on every channel.
// - Per-channel line select chooses which receiver feeds clock recovery.
// - Loopback routes transmit stream into recovery; no external receiver selected.
// - Link good only if amplitude, density, range, enable, refclk, no lockout.
// - Link fault output updates only on the selected receive clock.
// - Threshold 00 disables amplitude check; 01/10/11 low/mid/high, all channels.
// - Amplitude monitor watches only the selected line receiver.
// - Loopback disables amplitude monitor; fault uses all checks except amplitude.
// - No transition for over six characters flags link fault.
// - Range control compares VCO with refclk; out of window forces then releases.
// - Range control interval is 4096 recovered character clocks.
// - Link fault held while VCO is forced onto the reference.
// - Recovery to no-fault may take up to one range interval.
// - Channel enable 0 powers down PLL and forces fault; 1 enables.
// - After re-enable, outputs may be indeterminate for up to 2 ms.
// - Reference is character rate or half character rate.
// - Recovery tracks reference while out of range, then returns to data.
module slfm_top
    import slfm_pkg::*;
#(
    parameter int RC_INTERVAL = RC_INTERVAL_CHARS,
    parameter int SETTLE_COUNT = SETTLE_CYCLES,
    parameter int REF_TIMEOUT = REF_TIMEOUT_CYCLES
)(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    input wire logic [NCH-1:0] recovered_clock_input,
    input wire logic [NCH-1:0] reference_clock_input,
    input wire logic [NCH-1:0] primary_line_input,
    input wire logic [NCH-1:0] secondary_line_input,
    input wire logic [2*NCH-1:0] primary_amp_level,
    input wire logic [2*NCH-1:0] secondary_amp_level,
    input wire logic [NCH-1:0] tx_serial_data,
    input wire logic [NCH-1:0] line_input_select,
    input wire logic [NCH-1:0] link_fault_lockout,
    output logic [NCH-1:0] link_fault_indicator,
    output logic [2*NCH-1:0] driver_data,
    output logic [2*NCH-1:0] driver_power,
    output logic [NCH-1:0] tx_logic_power,
    output logic [NCH-1:0] rx_channel_power,
    output logic [2*NCH-1:0] receiver_route,
    output logic [NCH-1:0] amp_monitor_enable,
    output logic [1:0] amplitude_threshold_select,
    output logic [NCH-1:0] cdr_data,
    output logic [NCH-1:0] cdr_track_reference
);

    localparam int RCW = $clog2(RC_INTERVAL);
    localparam int SCW = $clog2(SETTLE_COUNT + 1);
    localparam int RTW = $clog2(REF_TIMEOUT + 1);
    localparam logic [RCW:0] EXP_FULL = (RCW+1)'(RC_INTERVAL);
    localparam logic [RCW:0] EXP_HALF = (RCW+1)'(RC_INTERVAL / 2);
    localparam logic [RCW:0] TOL = (RCW+1)'((RC_INTERVAL * RC_WINDOW_PPM) / 1000000);
    localparam logic [RCW-1:0] RC_LAST = RCW'(RC_INTERVAL - 1);
    localparam logic [3:0] TRANS_LIMIT = 4'(TRANS_MAX_CHARS);

    if (RC_INTERVAL < 16 || (RC_INTERVAL & (RC_INTERVAL - 1)) != 0)
        $error("RC_INTERVAL must be a power of two of at least 16");
    if (SETTLE_COUNT < 1 || REF_TIMEOUT < 4)
        $error("SETTLE_COUNT and REF_TIMEOUT too small");

    function automatic logic amp_pass(input logic [1:0] thr, input logic [1:0] lvl);
        amp_pass = (thr == AMP_DISABLED) || (lvl >= thr);
    endfunction

    function automatic logic [RCW:0] abs_diff(input logic [RCW:0] a, input logic [RCW:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction

    // Pin synchronisers
    slfm_pin_type pin_raw;
    slfm_pin_type pin_meta_ff;
    slfm_pin_type pin_sync_ff;

    assign pin_raw = '{
        secondary_amp: secondary_amp_level,
        primary_amp: primary_amp_level,
        lockout: link_fault_lockout,
        line_sel: line_input_select,
        tx_bit: tx_serial_data,
        secondary_bit: secondary_line_input,
        primary_bit: primary_line_input,
        ref_clk: reference_clock_input,
        rx_clk: recovered_clock_input
    };

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end
        else
        begin
            pin_meta_ff <= pin_raw;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    // Register state
    slfm_ctrl_type ctrl_ff;
    logic [2*NCH-1:0] drv_en_ff;
    slfm_status_type status;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic addr_phase;
    logic [31:0] rd_value;

    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);

    always_comb
    begin
        rd_value = 32'h0000_0000;
        if (wr_pend_ff && wr_addr_ff == haddr[7:0] && haddr[7:0] == CTRL_OFFSET)
            rd_value = hwdata & CTRL_MASK;
        else if (wr_pend_ff && wr_addr_ff == haddr[7:0] && haddr[7:0] == DRV_EN_OFFSET)
            rd_value = hwdata & DRV_EN_MASK;
        else if (haddr[7:0] == CTRL_OFFSET)
            rd_value = 32'(ctrl_ff);
        else if (haddr[7:0] == DRV_EN_OFFSET)
            rd_value = 32'(drv_en_ff);
        else if (haddr[7:0] == STATUS_OFFSET)
            rd_value = 32'(status);
    end

    // AHB-Lite slave, zero wait states
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
            if (hready)
            begin
                wr_pend_ff <= addr_phase && hwrite;
                wr_addr_ff <= haddr[7:0];
            end
            if (addr_phase && !hwrite)
                hrdata <= rd_value;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff <= slfm_ctrl_type'(CTRL_RESET[$bits(slfm_ctrl_type)-1:0]);
            drv_en_ff <= DRV_EN_RESET;
        end
        else if (wr_pend_ff)
        begin
            if (wr_addr_ff == CTRL_OFFSET)
                ctrl_ff <= slfm_ctrl_type'(hwdata[$bits(slfm_ctrl_type)-1:0]);
            else if (wr_addr_ff == DRV_EN_OFFSET)
                drv_en_ff <= hwdata[2*NCH-1:0];
        end
    end

    // Clock edge detection
    logic [NCH-1:0] rx_prev_ff;
    logic [NCH-1:0] ref_prev_ff;
    logic [NCH-1:0] rx_edge;
    logic [NCH-1:0] ref_edge;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_prev_ff <= '0;
            ref_prev_ff <= '0;
        end
        else
        begin
            rx_prev_ff <= pin_sync_ff.rx_clk;
            ref_prev_ff <= pin_sync_ff.ref_clk;
        end
    end

    assign rx_edge = pin_sync_ff.rx_clk & ~rx_prev_ff;
    assign ref_edge = pin_sync_ff.ref_clk & ~ref_prev_ff;

    // Selected recovery input and amplitude check
    logic [NCH-1:0] sel_bit;
    logic [NCH-1:0] amp_ok;

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            if (ctrl_ff.loopback[i])
                sel_bit[i] = pin_sync_ff.tx_bit[i];
            else if (pin_sync_ff.line_sel[i])
                sel_bit[i] = pin_sync_ff.secondary_bit[i];
            else
                sel_bit[i] = pin_sync_ff.primary_bit[i];
            if (ctrl_ff.loopback[i])
                amp_ok[i] = 1'b1;
            else if (pin_sync_ff.line_sel[i])
                amp_ok[i] = amp_pass(ctrl_ff.amp_threshold,
                    pin_sync_ff.secondary_amp[2*i +: 2]);
            else
                amp_ok[i] = amp_pass(ctrl_ff.amp_threshold,
                    pin_sync_ff.primary_amp[2*i +: 2]);
        end
    end

    // Transition density
    logic [NCH-1:0] last_bit_ff;
    logic [3:0] quiet_ff [NCH];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            last_bit_ff <= '0;
            for (int i = 0; i < NCH; i++)
                quiet_ff[i] <= 4'h0;
        end
        else
        begin
            last_bit_ff <= sel_bit;
            for (int i = 0; i < NCH; i++)
            begin
                if (sel_bit[i] != last_bit_ff[i])
                    quiet_ff[i] <= 4'h0;
                else if (rx_edge[i] && quiet_ff[i] <= TRANS_LIMIT)
                    quiet_ff[i] <= quiet_ff[i] + 4'h1;
            end
        end
    end

    // Reference clock presence
    logic [RTW-1:0] ref_idle_ff [NCH];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            for (int i = 0; i < NCH; i++)
                ref_idle_ff[i] <= RTW'(REF_TIMEOUT);
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (ref_edge[i])
                    ref_idle_ff[i] <= '0;
                else if (ref_idle_ff[i] != RTW'(REF_TIMEOUT))
                    ref_idle_ff[i] <= ref_idle_ff[i] + 1'b1;
            end
        end
    end

    // Range control
    logic [RCW-1:0] rc_chars_ff [NCH];
    logic [RCW:0] rc_refs_ff [NCH];
    logic [NCH-1:0] forced_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            forced_ff <= '0;
            for (int i = 0; i < NCH; i++)
            begin
                rc_chars_ff[i] <= '0;
                rc_refs_ff[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (!ctrl_ff.rx_enable[i])
                begin
                    forced_ff[i] <= 1'b0;
                    rc_chars_ff[i] <= '0;
                    rc_refs_ff[i] <= '0;
                end
                else if (rx_edge[i] && rc_chars_ff[i] == RC_LAST)
                begin
                    rc_chars_ff[i] <= '0;
                    rc_refs_ff[i] <= {{RCW{1'b0}}, ref_edge[i]};
                    if (forced_ff[i])
                        forced_ff[i] <= 1'b0;
                    else if (abs_diff(rc_refs_ff[i], ctrl_ff.refclk_mult[i] ?
                        EXP_HALF : EXP_FULL) > TOL)
                        forced_ff[i] <= 1'b1;
                end
                else
                begin
                    if (rx_edge[i])
                        rc_chars_ff[i] <= rc_chars_ff[i] + 1'b1;
                    if (ref_edge[i] && rc_refs_ff[i] != '1)
                        rc_refs_ff[i] <= rc_refs_ff[i] + 1'b1;
                end
            end
        end
    end

    // Settling window after re-enable
    logic [SCW-1:0] settle_ff [NCH];
    logic [NCH-1:0] rx_en_prev_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_en_prev_ff <= '0;
            for (int i = 0; i < NCH; i++)
                settle_ff[i] <= '0;
        end
        else
        begin
            rx_en_prev_ff <= ctrl_ff.rx_enable;
            for (int i = 0; i < NCH; i++)
            begin
                if (ctrl_ff.rx_enable[i] && !rx_en_prev_ff[i])
                    settle_ff[i] <= SCW'(SETTLE_COUNT);
                else if (settle_ff[i] != '0)
                    settle_ff[i] <= settle_ff[i] - 1'b1;
            end
        end
    end

    // Status word, one driver for all fields
    always_comb
    begin
        status = '0;
        for (int i = 0; i < NCH; i++)
        begin
            status.trans_ok[i] = (quiet_ff[i] <= TRANS_LIMIT);
            status.ref_present[i] = (ref_idle_ff[i] != RTW'(REF_TIMEOUT));
            status.settling[i] = (settle_ff[i] != '0);
        end
        status.vco_forced = forced_ff;
        status.link_ok = link_fault_indicator;
    end

    // Link fault indicator, high means link good
    logic [NCH-1:0] nxt_link_ok;

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
            nxt_link_ok[i] = amp_ok[i] && status.trans_ok[i] && !forced_ff[i]
                && ctrl_ff.rx_enable[i] && status.ref_present[i]
                && !pin_sync_ff.lockout[i];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            link_fault_indicator <= '0;
        else
        begin
            for (int i = 0; i < NCH; i++)
                if (rx_edge[i])
                    link_fault_indicator[i] <= nxt_link_ok[i];
        end
    end

    // Driver, power and routing outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            driver_data <= '0;
            driver_power <= '0;
            tx_logic_power <= '0;
            rx_channel_power <= '0;
            receiver_route <= '0;
            amp_monitor_enable <= '0;
            amplitude_threshold_select <= AMP_DISABLED;
            cdr_data <= '0;
            cdr_track_reference <= '0;
        end
        else
        begin
            driver_power <= drv_en_ff;
            amplitude_threshold_select <= ctrl_ff.amp_threshold;
            cdr_data <= sel_bit;
            cdr_track_reference <= forced_ff;
            rx_channel_power <= ctrl_ff.rx_enable;
            for (int i = 0; i < NCH; i++)
            begin
                for (int d = 0; d < 2; d++)
                    driver_data[2*i+d] <= drv_en_ff[2*i+d] &&
                        (ctrl_ff.loopback[i] || pin_sync_ff.tx_bit[i]);
                tx_logic_power[i] <= |drv_en_ff[2*i +: 2];
                receiver_route[2*i] <= !ctrl_ff.loopback[i] &&
                    !pin_sync_ff.line_sel[i];
                receiver_route[2*i+1] <= !ctrl_ff.loopback[i] &&
                    pin_sync_ff.line_sel[i];
                amp_monitor_enable[i] <= !ctrl_ff.loopback[i] &&
                    ctrl_ff.rx_enable[i] && ctrl_ff.amp_threshold != AMP_DISABLED;
            end
        end
    end

endmodule // slfm_top

/* dv/slfm_monitor.sv */
`timescale 1ns/1ps
module slfm_monitor
    import slfm_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic [1:0] hresp,
    input wire logic [NCH-1:0] recovered_clock_input,
    input wire logic [NCH-1:0] link_fault_indicator,
    input wire logic [2*NCH-1:0] driver_data,
    input wire logic [2*NCH-1:0] driver_power,
    input wire logic [NCH-1:0] tx_logic_power,
    input wire logic [NCH-1:0] rx_channel_power,
    input wire logic [2*NCH-1:0] receiver_route,
    input wire logic [NCH-1:0] amp_monitor_enable,
    input wire logic [1:0] amplitude_threshold_select,
    input wire logic [NCH-1:0] cdr_track_reference
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    function automatic logic [3:0] por(input logic [7:0] p);
        for (int i = 0; i < 4; i++)
            por[i] = p[2*i] | p[2*i+1];
    endfunction
    AST_READY: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus answer not ready or not okay");
    AST_RESET: assert property (disable iff (1'b0) !hresetn |-> driver_power == 8'h00)
        else $error("driver enabled during reset");
    AST_TXPWR: assert property (driver_power == $past(driver_power, 2)
        |-> tx_logic_power == por(driver_power))
        else $error("transmit logic power wrong");
    AST_DRV: assert property (driver_power == $past(driver_power)
        |-> (driver_data & ~driver_power) == 8'h00)
        else $error("disabled driver not quiet");
    AST_ROUTE: assert property ((receiver_route & (receiver_route >> 1) & 8'h55) == 8'h00)
        else $error("two receivers routed");
    AST_AMP: assert property (amplitude_threshold_select == $past(amplitude_threshold_select, 2)
        && rx_channel_power == $past(rx_channel_power, 2)
        |-> (amp_monitor_enable & ~rx_channel_power) == 4'h0
        && (amplitude_threshold_select != AMP_DISABLED || amp_monitor_enable == 4'h0))
        else $error("amplitude monitor enable wrong");
    genvar i;
    generate
        for (i = 0; i < NCH; i++)
        begin : g_ch
            logic prev_ff;
            logic [4:0] age_ff;
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                begin
                    prev_ff <= 1'b0;
                    age_ff <= 5'h1f;
                end
                else
                begin
                    prev_ff <= recovered_clock_input[i];
                    age_ff <= (recovered_clock_input[i] && !prev_ff) ? 5'h00
                        : age_ff + {4'h0, age_ff != 5'h1f};
                end
            end
            AST_LFI_SYNC: assert property ($changed(link_fault_indicator[i]) |-> age_ff <= 5'h05)
                else $error("indicator moved off recovered clock");
            AST_DIS: assert property (!rx_channel_power[i] && link_fault_indicator[i]
                |-> ##[1:40] !link_fault_indicator[i])
                else $error("disabled channel not in fault");
            AST_FORCED: assert property ($rose(link_fault_indicator[i])
                |-> !$past(cdr_track_reference[i], 2))
                else $error("indicator good while forced");
        end
    endgenerate
    cover property (link_fault_indicator == 4'hf);
    cover property (cdr_track_reference[0]);
    cover property (driver_data == 8'hff);
endmodule // slfm_monitor

bind slfm_top slfm_monitor i_mon (.*);

/* dv/slfm_remote_tx.sv */
`timescale 1ns/1ps
module slfm_remote_tx
    import slfm_pkg::*;
(
    input wire logic hold_pri,
    output logic [NCH-1:0] recovered_clock_input,
    output logic [NCH-1:0] reference_clock_input,
    output logic [NCH-1:0] primary_line_input,
    output logic [NCH-1:0] secondary_line_input
);
    initial
    begin
        recovered_clock_input = '0;
        reference_clock_input = '0;
        primary_line_input = '0;
        secondary_line_input = '1;
        fork
            forever #62.5 recovered_clock_input = ~recovered_clock_input;
            #31 forever #62.5 reference_clock_input = ~reference_clock_input;
            // New bit each character unless held
            forever
            begin
                @(posedge recovered_clock_input[0]);
                if (!hold_pri)
                    primary_line_input <= ~primary_line_input;
                secondary_line_input <= ~secondary_line_input;
            end
        join
    end
endmodule // slfm_remote_tx

/* dv/slfm_top_tb.sv */
`timescale 1ns/1ps
module slfm_top_tb;
    import slfm_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hold_pri;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, hresp, amplitude_threshold_select;
    logic [2:0] hsize;
    logic [NCH-1:0] recovered_clock_input, reference_clock_input, primary_line_input;
    logic [NCH-1:0] secondary_line_input, tx_serial_data, line_input_select;
    logic [NCH-1:0] link_fault_lockout, link_fault_indicator, tx_logic_power;
    logic [NCH-1:0] rx_channel_power, amp_monitor_enable, cdr_data, cdr_track_reference;
    logic [2*NCH-1:0] primary_amp_level, secondary_amp_level, driver_data, driver_power;
    logic [2*NCH-1:0] receiver_route;
    logic [7:0] pat [3] = '{8'h3c, 8'h81, 8'hff};
    int n_fail, num_checks;
    assign hready = hreadyout;
    slfm_top #(.RC_INTERVAL(64), .SETTLE_COUNT(20), .REF_TIMEOUT(64)) i_dut (.*);
    slfm_remote_tx i_far (.*);
    initial
    begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic rdy();
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hready !== 1'b1 && k < 50);
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        q = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
        idle(2);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        cmp("hrdata", e, q);
    endtask
    task automatic wait_lfi(input logic [3:0] e);
        for (int k = 0; k < 5000 && link_fault_indicator !== e; k++)
            @(posedge hclk);
        cmp("link_fault_indicator", e, link_fault_indicator);
    endtask
    initial
    begin
        #800000;
        n_fail++;
        finish_test();
    end
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = '0;
        hold_pri = 1'b0;
        tx_serial_data = '0;
        line_input_select = '0;
        link_fault_lockout = '0;
        primary_amp_level = 8'hff;
        secondary_amp_level = 8'hff;
        n_fail = 0;
        num_checks = 0;
        idle(3);
        hresetn <= 1'b1;
        idle(1);
        rdc(CTRL_OFFSET, CTRL_RESET);
        rdc(DRV_EN_OFFSET, {24'h0, DRV_EN_RESET});
        rdc(8'h40, 32'h0);
        foreach (pat[j])
        begin
            wr(DRV_EN_OFFSET, {24'h0, pat[j]});
            cmp("driver_power", pat[j], driver_power);
            cmp("tx_logic_power", {pat[j][6] | pat[j][7], pat[j][4] | pat[j][5],
                pat[j][2] | pat[j][3], pat[j][0] | pat[j][1]}, tx_logic_power);
        end
        tx_serial_data <= 4'ha;
        idle(4);
        cmp("driver_data", 8'hcc, driver_data);
        wr(CTRL_OFFSET, 32'h0000000f);
        cmp("driver_data", 8'hff, driver_data);
        cmp("receiver_route", 8'h00, receiver_route);
        cmp("cdr_data", 4'ha, cdr_data);
        wr(DRV_EN_OFFSET, 32'h3c);
        cmp("driver_data", 8'h3c, driver_data);
        hresetn <= 1'b0;
        idle(3);
        hresetn <= 1'b1;
        idle(1);
        cmp("driver_power", 8'h00, driver_power);
        rdc(DRV_EN_OFFSET, 32'h0);
        $display("test drivers done");
        for (int t = 0; t < 4; t++)
        begin
            wr(CTRL_OFFSET, {18'h0, t[1:0], 12'h0f0});
            cmp("amplitude_threshold_select", t[1:0], amplitude_threshold_select);
            cmp("amp_monitor_enable", (t != 0) ? 4'hf : 4'h0, amp_monitor_enable);
        end
        wr(CTRL_OFFSET, 32'h000030ff);
        cmp("amp_monitor_enable", 4'h0, amp_monitor_enable);
        line_input_select <= 4'h5;
        wr(CTRL_OFFSET, 32'h000000f0);
        idle(3);
        cmp("receiver_route", 8'h66, receiver_route);
        $display("test routing done");
        wait_lfi(4'hf);
        rdc(STATUS_OFFSET, 32'h0000ff0f);
        link_fault_lockout <= 4'h2;
        wait_lfi(4'hd);
        link_fault_lockout <= 4'h0;
        wait_lfi(4'hf);
        primary_amp_level <= 8'haa;
        wr(CTRL_OFFSET, 32'h000030f0);
        wait_lfi(4'h5);
        wr(CTRL_OFFSET, 32'h000020f0);
        wait_lfi(4'hf);
        hold_pri <= 1'b1;
        wait_lfi(4'h5);
        line_input_select <= 4'hf;
        wait_lfi(4'hf);
        hold_pri <= 1'b0;
        wr(CTRL_OFFSET, 32'h000020b0);
        wait_lfi(4'hb);
        cmp("rx_channel_power", 4'hb, rx_channel_power);
        $display("test link fault done");
        wr(CTRL_OFFSET, 32'h000021f0);
        for (int k = 0; k < 5000 && cdr_track_reference[0] !== 1'b1; k++)
            @(posedge hclk);
        idle(40);
        cmp("cdr_track_reference", 1'b1, cdr_track_reference[0]);
        cmp("link_fault_indicator", 1'b0, link_fault_indicator[0]);
        wr(CTRL_OFFSET, 32'h000020f0);
        wait_lfi(4'hf);
        cmp("cdr_track_reference", 4'h0, cdr_track_reference);
        $display("test range control done");
        finish_test();
    end
endmodule // slfm_top_tb
